// ==== flash_ctl_pkg.sv ====
// constants, types and register map of the flash command and status block
package flash_ctl_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFS_CONFIG   = 8'h00;
   localparam logic [7:0] OFS_PROT     = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_CMD      = 8'h0c;
   localparam logic [7:0] OFS_DIV      = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   // command codes
   localparam logic [7:0] CMD_BLANK = 8'h05;
   localparam logic [7:0] CMD_BYTE  = 8'h20;
   localparam logic [7:0] CMD_BURST = 8'h25;
   localparam logic [7:0] CMD_PAGE  = 8'h40;
   localparam logic [7:0] CMD_MASS  = 8'h41;
   // config: writable bits and key-write select position
   localparam logic [7:0] CONFIG_MASK = 8'he0;
   localparam int         KEY_SEL     = 5;
   localparam logic [7:0] CONFIG_RST  = 8'h00;
   // status bit positions
   localparam int BEF    = 7;
   localparam int CCF    = 6;
   localparam int PVIOL  = 5;
   localparam int ACCERR = 4;
   localparam int BLANK  = 2;
   // backdoor key window and page size
   localparam logic [15:0] KEY_LO     = 16'hffb0;
   localparam logic [15:0] KEY_HI     = 16'hffb7;
   localparam int          PAGE_SHIFT = 9;
   // interrupt status / mask bits
   localparam int IRQ_W    = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_PV   = 1;
   localparam int IRQ_AE   = 2;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic [7:0]  cmd;
      logic [15:0] addr;
      logic [7:0]  data;
   } op_req_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_DATA = 2'b01,
      SEQ_CMD  = 2'b10
   } seq_t;
endpackage

// ==== flash_ctl.sv ====
// flash command sequencer with status, protection and APB register file
//
// Summary of operation
// - config upper three bits RW, lower read zero
// - key select routes key-window writes to key
// - protection loaded from stored byte one clock after reset release
// - enabled protection may only shrink boundary
// - boundary field marks end of unprotected range
// - disable bit set means nothing protected
// - status bits 3,1,0 read zero, ignore writes
// - writing one to buffer empty launches command
// - only burst program commands are buffered behind a running burst
// - complete set when idle, cleared on launch
// - protected target ignored, sets violation flag
// - sequence, divider, stop faults set access error
// - blank flag set when a blank check finds array all erased
// - codes 05, 20, 25 recognised
// - codes 40 page, 41 mass erase recognised
// - other codes give access error
// - divider write enables program and erase
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module flash_ctl (
   input  wire logic                  CLOCK,
   input  wire logic                  ARST_N,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [7:0]            PADDR,
   input  wire logic [31:0]           PWDATA,
   output logic      [31:0]           PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   input  wire logic [7:0]            STORED_PROT,
   input  wire logic                  ARRAY_WR,
   input  wire logic [15:0]           ARRAY_ADDR,
   input  wire logic [7:0]            ARRAY_DATA,
   input  wire logic                  STOP_ENTRY,
   input  wire logic                  OP_DONE,
   input  wire logic                  OP_ALL_BLANK,
   output logic                       OP_START,
   output flash_ctl_pkg::op_req_t     OP_REQ,
   output logic                       KEY_WR,
   output logic      [2:0]            KEY_INDEX,
   output logic      [7:0]            KEY_DATA,
   output logic                       IRQ
);
   logic                          rst_meta;
   logic                          rst_n;
   logic [7:0]                    config_reg;
   logic [7:0]                    prot;
   logic                          prot_loaded;
   logic [7:0]                    divider;
   logic                          div_loaded;
   logic                          bef;
   logic                          busy;
   logic                          cur_burst;
   logic                          cur_blank;
   logic                          pend;
   flash_ctl_pkg::op_req_t        pend_req;
   flash_ctl_pkg::op_req_t        seq_req;
   flash_ctl_pkg::seq_t           seq;
   logic                          pviol;
   logic                          accerr;
   logic                          blank;
   logic                          ccf;
   logic                          ccf_q;
   logic [flash_ctl_pkg::IRQ_W-1:0] irq_stat;
   logic [flash_ctl_pkg::IRQ_W-1:0] irq_mask;
   logic [flash_ctl_pkg::IRQ_W-1:0] irq_ev;
   logic                          irq_any;
   logic                          wr_acc;
   logic                          rd_acc;
   logic                          setup;
   logic                          key_hit;
   logic                          launch;
   logic                          launch_ok;
   logic                          viol_now;
   logic                          start;
   logic                          seq_err;
   logic [7:0]                    status;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == flash_ctl_pkg::OFS_CONFIG) || (a == flash_ctl_pkg::OFS_PROT)
            || (a == flash_ctl_pkg::OFS_STATUS) || (a == flash_ctl_pkg::OFS_CMD)
            || (a == flash_ctl_pkg::OFS_DIV) || (a == flash_ctl_pkg::OFS_IRQ_STAT)
            || (a == flash_ctl_pkg::OFS_IRQ_MASK);
   endfunction

   function automatic logic legal_cmd(input logic [7:0] c);
      legal_cmd = (c == flash_ctl_pkg::CMD_BLANK) || (c == flash_ctl_pkg::CMD_BYTE)
               || (c == flash_ctl_pkg::CMD_BURST) || (c == flash_ctl_pkg::CMD_PAGE)
               || (c == flash_ctl_pkg::CMD_MASS);
   endfunction

   // mass erase counts as touching the protected block whenever protection is enabled
   function automatic logic hits_protected(input flash_ctl_pkg::op_req_t r,
                                           input logic [7:0] p);
      if (p[0] || r.cmd == flash_ctl_pkg::CMD_BLANK)
         hits_protected = 1'b0;
      else if (r.cmd == flash_ctl_pkg::CMD_MASS)
         hits_protected = 1'b1;
      else
         hits_protected = r.addr[15:flash_ctl_pkg::PAGE_SHIFT] > p[7:1];
   endfunction

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign setup   = PSEL && !PENABLE;
   assign wr_acc  = PSEL && PENABLE && PREADY && PWRITE && mapped(PADDR);
   assign rd_acc  = PSEL && PENABLE && PREADY && !PWRITE;
   assign key_hit = config_reg[flash_ctl_pkg::KEY_SEL] && ARRAY_ADDR >= flash_ctl_pkg::KEY_LO
                    && ARRAY_ADDR <= flash_ctl_pkg::KEY_HI;
   assign launch    = wr_acc && PADDR == flash_ctl_pkg::OFS_STATUS
                      && PWDATA[flash_ctl_pkg::BEF];
   assign viol_now  = hits_protected(seq_req, prot);
   // only a burst may wait behind a running burst
   assign launch_ok = launch && seq == flash_ctl_pkg::SEQ_CMD && !viol_now
                      && (!busy || (cur_burst && !pend
                      && seq_req.cmd == flash_ctl_pkg::CMD_BURST));
   assign start     = pend && (!busy || OP_DONE);
   assign ccf       = bef && !busy && !pend;
   assign status    = {bef, ccf, pviol, accerr, 1'b0, blank, 2'b00};

   // fault in the command sequence, before the divider, or stop mid-command
   always_comb begin
      seq_err = 1'b0;
      if (ARRAY_WR && !key_hit && (!div_loaded || seq != flash_ctl_pkg::SEQ_IDLE || !bef))
         seq_err = 1'b1;
      if (wr_acc && PADDR == flash_ctl_pkg::OFS_CMD
          && (seq != flash_ctl_pkg::SEQ_DATA || !legal_cmd(PWDATA[7:0])))
         seq_err = 1'b1;
      if (launch && !launch_ok && !(seq == flash_ctl_pkg::SEQ_CMD && viol_now))
         seq_err = 1'b1;
      if (STOP_ENTRY && busy)
         seq_err = 1'b1;
   end

   // apb slave: zero wait, data and error prepared in the setup cycle
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= flash_ctl_pkg::RD_ZERO;
      end else begin
         PREADY  <= setup;
         PSLVERR <= setup && !mapped(PADDR);
         PRDATA  <= flash_ctl_pkg::RD_ZERO;
         if (setup && !PWRITE) begin
            case (PADDR)
               flash_ctl_pkg::OFS_CONFIG:   PRDATA[7:0] <= config_reg;
               flash_ctl_pkg::OFS_PROT:     PRDATA[7:0] <= prot;
               flash_ctl_pkg::OFS_STATUS:   PRDATA[7:0] <= status;
               flash_ctl_pkg::OFS_DIV:      PRDATA[7:0] <= {div_loaded, divider[6:0]};
               flash_ctl_pkg::OFS_IRQ_STAT: PRDATA[flash_ctl_pkg::IRQ_W-1:0] <= irq_stat;
               flash_ctl_pkg::OFS_IRQ_MASK: PRDATA[flash_ctl_pkg::IRQ_W-1:0] <= irq_mask;
               default:                     PRDATA <= flash_ctl_pkg::RD_ZERO;
            endcase
         end
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         config_reg <= flash_ctl_pkg::CONFIG_RST;
         divider    <= 8'h00;
         div_loaded <= 1'b0;
         irq_mask   <= '0;
      end else if (wr_acc) begin
         if (PADDR == flash_ctl_pkg::OFS_CONFIG)
            config_reg <= PWDATA[7:0] & flash_ctl_pkg::CONFIG_MASK;
         if (PADDR == flash_ctl_pkg::OFS_DIV) begin
            divider    <= PWDATA[7:0];
            div_loaded <= 1'b1;
         end
         if (PADDR == flash_ctl_pkg::OFS_IRQ_MASK)
            irq_mask <= PWDATA[flash_ctl_pkg::IRQ_W-1:0];
      end
   end

   // stored byte is caught by a clocked load after reset release
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         prot        <= 8'h00;
         prot_loaded <= 1'b0;
      end else if (!prot_loaded) begin
         prot        <= STORED_PROT;
         prot_loaded <= 1'b1;
      end else if (wr_acc && PADDR == flash_ctl_pkg::OFS_PROT && !prot[0]
                   && PWDATA[7:1] < prot[7:1]) begin
         prot[7:1] <= PWDATA[7:1];
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         KEY_WR    <= 1'b0;
         KEY_INDEX <= 3'h0;
         KEY_DATA  <= 8'h00;
      end else begin
         KEY_WR <= ARRAY_WR && key_hit;
         if (ARRAY_WR && key_hit) begin
            KEY_INDEX <= ARRAY_ADDR[2:0];
            KEY_DATA  <= ARRAY_DATA;
         end
      end
   end

   // command sequence: array write, command code, then launch
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         seq     <= flash_ctl_pkg::SEQ_IDLE;
         seq_req <= '0;
      end else if (seq_err || launch) begin
         seq <= flash_ctl_pkg::SEQ_IDLE;
      end else if (ARRAY_WR && !key_hit) begin
         seq          <= flash_ctl_pkg::SEQ_DATA;
         seq_req.addr <= ARRAY_ADDR;
         seq_req.data <= ARRAY_DATA;
      end else if (wr_acc && PADDR == flash_ctl_pkg::OFS_CMD) begin
         seq         <= flash_ctl_pkg::SEQ_CMD;
         seq_req.cmd <= PWDATA[7:0];
      end
   end

   // launch buffer and array engine handshake
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         bef       <= 1'b1;
         pend      <= 1'b0;
         pend_req  <= '0;
         busy      <= 1'b0;
         cur_burst <= 1'b0;
         cur_blank <= 1'b0;
         OP_START  <= 1'b0;
         OP_REQ    <= '0;
      end else begin
         OP_START <= start;
         if (start) begin
            OP_REQ    <= pend_req;
            busy      <= 1'b1;
            cur_burst <= pend_req.cmd == flash_ctl_pkg::CMD_BURST;
            cur_blank <= pend_req.cmd == flash_ctl_pkg::CMD_BLANK;
            pend      <= 1'b0;
            bef       <= 1'b1;
         end else if (OP_DONE) begin
            busy <= 1'b0;
         end
         if (launch_ok) begin
            pend     <= 1'b1;
            pend_req <= seq_req;
            bef      <= 1'b0;
         end
      end
   end

   // flags: hardware set wins over a write-one clear in the same cycle
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         pviol  <= 1'b0;
         accerr <= 1'b0;
         blank  <= 1'b0;
      end else begin
         if (launch && seq == flash_ctl_pkg::SEQ_CMD && viol_now)
            pviol <= 1'b1;
         else if (wr_acc && PADDR == flash_ctl_pkg::OFS_STATUS && PWDATA[flash_ctl_pkg::PVIOL])
            pviol <= 1'b0;
         if (seq_err)
            accerr <= 1'b1;
         else if (wr_acc && PADDR == flash_ctl_pkg::OFS_STATUS && PWDATA[flash_ctl_pkg::ACCERR])
            accerr <= 1'b0;
         if (OP_DONE && busy && cur_blank && OP_ALL_BLANK)
            blank <= 1'b1;
         else if (launch_ok)
            blank <= 1'b0;
      end
   end

   assign irq_ev[flash_ctl_pkg::IRQ_DONE] = ccf && !ccf_q;
   assign irq_ev[flash_ctl_pkg::IRQ_PV]   = launch && seq == flash_ctl_pkg::SEQ_CMD && viol_now;
   assign irq_ev[flash_ctl_pkg::IRQ_AE]   = seq_err;
   assign irq_any = |(irq_stat & irq_mask);

   // a read clears the status, but an event in that cycle still lands
   for (genvar i = 0; i < flash_ctl_pkg::IRQ_W; i++) begin : g_irq
      always_ff @(posedge CLOCK or negedge rst_n) begin
         if (!rst_n)
            irq_stat[i] <= 1'b0;
         else if (irq_ev[i])
            irq_stat[i] <= 1'b1;
         else if (rd_acc && PADDR == flash_ctl_pkg::OFS_IRQ_STAT)
            irq_stat[i] <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         ccf_q <= 1'b1;
         IRQ   <= 1'b0;
      end else begin
         ccf_q <= ccf;
         IRQ   <= irq_any;
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!rst_n);

   sequence s_launch_ok;
      launch_ok;
   endsequence
   sequence s_cleared;
      !bef ##0 !ccf ##0 !blank;
   endsequence

   a_config_low_zero: assert property (config_reg[4:0] == 5'h00)
      else $error("config low bits not zero");
   a_key_route: assert property (ARRAY_WR && key_hit |=> KEY_WR && seq == $past(seq))
      else $error("key write not routed");
   a_prot_load: assert property ($rose(prot_loaded) |-> prot == $past(STORED_PROT))
      else $error("protection not loaded");
   a_prot_shrink: assert property (prot_loaded && $past(prot_loaded) |->
      prot[7:1] <= $past(prot[7:1]) && prot[0] == $past(prot[0]))
      else $error("protection was relaxed");
   a_viol_ignored: assert property (launch && seq == flash_ctl_pkg::SEQ_CMD && viol_now
      |=> pviol && bef && !pend)
      else $error("violating command not ignored");
   a_status_zero: assert property (setup && !PWRITE && PADDR == flash_ctl_pkg::OFS_STATUS
      |=> PRDATA[3] == 1'b0 && PRDATA[1:0] == 2'b00)
      else $error("status reserved bits set");
   a_launch_flow: assert property (s_launch_ok |=> s_cleared ##1 (pend || busy))
      else $error("launch did not clear flags");
   a_burst_only: assert property (launch_ok && busy |-> seq_req.cmd == flash_ctl_pkg::CMD_BURST)
      else $error("non burst command buffered");
   a_ccf_level: assert property (busy |-> !ccf)
      else $error("complete while busy");
   a_nodiv_err: assert property (ARRAY_WR && !key_hit && !div_loaded
      |=> accerr && seq == flash_ctl_pkg::SEQ_IDLE)
      else $error("no access error before divider");
   a_illegal_cmd: assert property (wr_acc && PADDR == flash_ctl_pkg::OFS_CMD
      && !legal_cmd(PWDATA[7:0]) |=> accerr ##1 !pend)
      else $error("illegal code accepted");
   a_blank_set: assert property (OP_DONE && busy && cur_blank && OP_ALL_BLANK |=> blank)
      else $error("blank flag not set");
   a_cmd_reads_zero: assert property (setup && !PWRITE && PADDR == flash_ctl_pkg::OFS_CMD
      |=> PRDATA == flash_ctl_pkg::RD_ZERO)
      else $error("command register read not zero");
   a_irq_level: assert property (##1 IRQ == $past(irq_any))
      else $error("interrupt level wrong");
endmodule

// ==== flash_ctl_tb.sv ====
// register-level testbench of the flash command and status block
`timescale 1ns/1ps
module flash_ctl_tb;
   logic                   clock = 1'b0;
   logic                   arst_n = 1'b0;
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [7:0]             paddr = 8'h00;
   logic [31:0]            pwdata = 32'h0000_0000;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [7:0]             stored_prot = 8'h80;
   logic                   array_wr = 1'b0;
   logic [15:0]            array_addr = 16'h0000;
   logic [7:0]             array_data = 8'h00;
   logic                   stop_entry = 1'b0;
   logic                   op_done = 1'b0;
   logic                   op_all_blank = 1'b0;
   logic                   op_start;
   flash_ctl_pkg::op_req_t op_req;
   logic                   key_wr;
   logic [2:0]             key_index;
   logic [7:0]             key_data;
   logic                   irq;
   int                     n_mismatch = 0;
   int                     tests_run = 0;
   int                     cycles = 0;
   logic [31:0]            rd;
   logic                   err;
   logic                   seen;

   flash_ctl u_dut (
      .CLOCK        (clock),
      .ARST_N       (arst_n),
      .PSEL         (psel),
      .PENABLE      (penable),
      .PWRITE       (pwrite),
      .PADDR        (paddr),
      .PWDATA       (pwdata),
      .PRDATA       (prdata),
      .PREADY       (pready),
      .PSLVERR      (pslverr),
      .STORED_PROT  (stored_prot),
      .ARRAY_WR     (array_wr),
      .ARRAY_ADDR   (array_addr),
      .ARRAY_DATA   (array_data),
      .STOP_ENTRY   (stop_entry),
      .OP_DONE      (op_done),
      .OP_ALL_BLANK (op_all_blank),
      .OP_START     (op_start),
      .OP_REQ       (op_req),
      .KEY_WR       (key_wr),
      .KEY_INDEX    (key_index),
      .KEY_DATA     (key_data),
      .IRQ          (irq)
   );

   always #5 clock = ~clock;

   task automatic stop_test;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // generous ceiling: the whole sequence needs under two thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // answers are sampled before the edge's own updates land
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic arr_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      array_wr <= 1'b1;
      array_addr <= a;
      array_data <= d;
      @(posedge clock);
      array_wr <= 1'b0;
      seen = 1'b0;
      repeat (3) begin
         @(posedge clock);
         if (key_wr === 1'b1 && !seen) begin
            seen = 1'b1;
            chk({key_index, key_data}, {a[2:0], d});
         end
      end
   endtask

   task automatic wait_start;
      seen = 1'b0;
      repeat (8) begin
         @(posedge clock);
         if (op_start === 1'b1) seen = 1'b1;
      end
   endtask

   task automatic pulse_done(input logic blank);
      @(posedge clock);
      op_done <= 1'b1;
      op_all_blank <= blank;
      @(posedge clock);
      op_done <= 1'b0;
   endtask

   // array write, command code, launch; then finish the operation if it started
   task automatic run(input logic [7:0] code, input logic [15:0] a, input logic blank,
                      input logic stop, input logic go, input logic [7:0] st);
      arr_wr(a, 8'h5a);
      apb(1'b1, flash_ctl_pkg::OFS_CMD, code);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h80);
      wait_start();
      chk(seen, go);
      if (seen) begin
         chk(op_req, {code, a, 8'h5a});
         apb(1'b0, flash_ctl_pkg::OFS_STATUS, 8'h00);
         chk(rd, 32'h0000_0080);
         if (stop) begin
            @(posedge clock);
            stop_entry <= 1'b1;
            @(posedge clock);
            stop_entry <= 1'b0;
         end
         pulse_done(blank);
      end
      apb(1'b0, flash_ctl_pkg::OFS_STATUS, 8'h00);
      chk(rd, {24'h000000, st});
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h30);
   endtask

   task automatic do_reset;
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (6) @(posedge clock);
   endtask

   initial begin
      do_reset();
      apb(1'b0, flash_ctl_pkg::OFS_STATUS, 8'h00);
      chk(rd, 32'h0000_00c0);
      apb(1'b0, flash_ctl_pkg::OFS_PROT, 8'h00);
      chk(rd, 32'h0000_0080);
      apb(1'b0, flash_ctl_pkg::OFS_CMD, 8'h00);
      chk(rd, 32'h0000_0000);
      apb(1'b1, flash_ctl_pkg::OFS_CMD, flash_ctl_pkg::CMD_BYTE);
      apb(1'b0, flash_ctl_pkg::OFS_CMD, 8'h00);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h1c, 8'h00);
      chk(rd, 32'h0000_0000);
      chk(err, 1'b1);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h30);
      apb(1'b1, flash_ctl_pkg::OFS_CONFIG, 8'hff);
      apb(1'b0, flash_ctl_pkg::OFS_CONFIG, 8'h00);
      chk(rd, 32'h0000_00e0);
      apb(1'b1, flash_ctl_pkg::OFS_CONFIG, 8'h20);
      arr_wr(16'hffb3, 8'ha5);
      chk(seen, 1'b1);
      // launch with no sequence pending shows that the key write started none
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h80);
      apb(1'b0, flash_ctl_pkg::OFS_STATUS, 8'h00);
      chk(rd, 32'h0000_00d0);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h3f);
      apb(1'b1, flash_ctl_pkg::OFS_CONFIG, 8'h00);
      apb(1'b1, flash_ctl_pkg::OFS_PROT, 8'hfe);
      apb(1'b0, flash_ctl_pkg::OFS_PROT, 8'h00);
      chk(rd, 32'h0000_0080);
      apb(1'b1, flash_ctl_pkg::OFS_PROT, 8'h70);
      apb(1'b0, flash_ctl_pkg::OFS_PROT, 8'h00);
      chk(rd, 32'h0000_0070);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h4f);
      apb(1'b0, flash_ctl_pkg::OFS_STATUS, 8'h00);
      chk(rd, 32'h0000_00c0);
      run(flash_ctl_pkg::CMD_BYTE, 16'h1000, 1'b0, 1'b0, 1'b0, 8'hd0);
      apb(1'b1, flash_ctl_pkg::OFS_DIV, 8'h13);
      apb(1'b0, flash_ctl_pkg::OFS_DIV, 8'h00);
      chk(rd, 32'h0000_0093);
      run(flash_ctl_pkg::CMD_BLANK, 16'h0000, 1'b1, 1'b0, 1'b1, 8'hc4);
      run(flash_ctl_pkg::CMD_BYTE, 16'h7000, 1'b0, 1'b0, 1'b1, 8'hc0);
      run(flash_ctl_pkg::CMD_BURST, 16'h1001, 1'b0, 1'b0, 1'b1, 8'hc0);
      run(flash_ctl_pkg::CMD_PAGE, 16'h2000, 1'b0, 1'b0, 1'b1, 8'hc0);
      run(flash_ctl_pkg::CMD_BLANK, 16'h0000, 1'b0, 1'b0, 1'b1, 8'hc0);
      run(flash_ctl_pkg::CMD_MASS, 16'h0000, 1'b0, 1'b0, 1'b0, 8'he0);
      run(flash_ctl_pkg::CMD_BYTE, 16'h7200, 1'b0, 1'b0, 1'b0, 8'he0);
      run(flash_ctl_pkg::CMD_BYTE, 16'hffb3, 1'b0, 1'b0, 1'b0, 8'he0);
      run(8'h33, 16'h1000, 1'b0, 1'b0, 1'b0, 8'hd0);
      run(flash_ctl_pkg::CMD_BYTE, 16'h1000, 1'b0, 1'b1, 1'b1, 8'hd0);
      // second burst waits in the buffer until the first one finishes
      arr_wr(16'h1100, 8'h11);
      apb(1'b1, flash_ctl_pkg::OFS_CMD, flash_ctl_pkg::CMD_BURST);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h80);
      wait_start();
      chk(seen, 1'b1);
      arr_wr(16'h1101, 8'h22);
      apb(1'b1, flash_ctl_pkg::OFS_CMD, flash_ctl_pkg::CMD_BURST);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h80);
      apb(1'b0, flash_ctl_pkg::OFS_STATUS, 8'h00);
      chk(rd, 32'h0000_0000);
      pulse_done(1'b0);
      wait_start();
      chk(seen, 1'b1);
      chk(op_req, {flash_ctl_pkg::CMD_BURST, 16'h1101, 8'h22});
      pulse_done(1'b0);
      apb(1'b0, flash_ctl_pkg::OFS_STATUS, 8'h00);
      chk(rd, 32'h0000_00c0);
      // interrupt: unmasked, read-clear, then masked
      apb(1'b0, flash_ctl_pkg::OFS_IRQ_STAT, 8'h00);
      apb(1'b1, flash_ctl_pkg::OFS_IRQ_MASK, 8'h04);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h80);
      repeat (3) @(posedge clock);
      chk(irq, 1'b1);
      apb(1'b0, flash_ctl_pkg::OFS_IRQ_STAT, 8'h00);
      chk(rd, 32'h0000_0004);
      repeat (3) @(posedge clock);
      chk(irq, 1'b0);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h10);
      apb(1'b1, flash_ctl_pkg::OFS_IRQ_MASK, 8'h00);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h80);
      repeat (3) @(posedge clock);
      chk(irq, 1'b0);
      apb(1'b0, flash_ctl_pkg::OFS_IRQ_STAT, 8'h00);
      chk(rd, 32'h0000_0004);
      apb(1'b1, flash_ctl_pkg::OFS_STATUS, 8'h10);
      // stored byte with protection disabled: nothing is protected
      stored_prot <= 8'h81;
      do_reset();
      apb(1'b0, flash_ctl_pkg::OFS_PROT, 8'h00);
      chk(rd, 32'h0000_0081);
      apb(1'b1, flash_ctl_pkg::OFS_PROT, 8'h01);
      apb(1'b0, flash_ctl_pkg::OFS_PROT, 8'h00);
      chk(rd, 32'h0000_0081);
      apb(1'b1, flash_ctl_pkg::OFS_DIV, 8'h00);
      run(flash_ctl_pkg::CMD_MASS, 16'h0000, 1'b0, 1'b0, 1'b1, 8'hc0);
      run(flash_ctl_pkg::CMD_BYTE, 16'hff00, 1'b0, 1'b0, 1'b1, 8'hc0);
      stop_test();
   end
endmodule
